// ---- design/pcc_params.svh ----
// Constants for the clock and reset-configuration block
`ifndef PCC_PARAMS_SVH
`define PCC_PARAMS_SVH

// ------------------------------------------------------------
// Clock figures
// ------------------------------------------------------------
`define PCC_CORE_CLK_MHZ 100
`define PCC_CORE_PER_REF 2
`define PCC_LOCK_REF_CYCLES 100000
`define PCC_RESET_OUT_N_BUS_CYCLES 16

// ------------------------------------------------------------
// Strap fields on the data lines
// ------------------------------------------------------------
`define PCC_STRAP_RATIO_LSB 0
`define PCC_STRAP_RATIO_MSB 1
`define PCC_STRAP_RANGE_LSB 2
`define PCC_STRAP_RANGE_MSB 3

// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define PCC_ADDR_W 8
`define PCC_ADDR_CTRL 8'h00
`define PCC_ADDR_STAT 8'h04
`define PCC_CTRL_RESET 8'h00
`define PCC_CTRL_STOP_BIT 7
`define PCC_CTRL_WAKE_MSB 6
`define PCC_CTRL_WAKE_LSB 4

// Status register fields
`define PCC_STAT_LOCKED_BIT 0
`define PCC_STAT_RESET_OUT_N_BIT 1
`define PCC_STAT_STOPPED_BIT 2
`define PCC_STAT_BAD_RANGE_BIT 3
`define PCC_STAT_RANGE_LSB 4
`define PCC_STAT_RATIO_LSB 6
`define PCC_STAT_STRAP_LSB 8

// ------------------------------------------------------------
// Codes
// ------------------------------------------------------------
`define PCC_RANGE_UNUSED 2'h3
`define PCC_RATIO_QUARTER 2'h0
`define PCC_RATIO_UNUSED 2'h1
`define PCC_RATIO_HALF 2'h2
`define PCC_RATIO_THIRD 2'h3
`define PCC_WAKE_NONE 3'h7
`define PCC_IRQ_NONE 3'h0

`endif

// ---- design/pcc_pkg.sv ----
// Types shared by the clock and reset-configuration block
package pcc_pkg;

  // Sequencer states after reset release
  typedef enum logic [1:0] {
    PCC_ST_LOCK = 2'b00,
    PCC_ST_EXTEND = 2'b01,
    PCC_ST_RUN = 2'b10
  } pcc_state_t;

  // Configuration caught from the data lines during reset
  typedef struct packed {
    logic [7:0] strap;
    logic [1:0] range;
    logic [1:0] ratio;
  } pcc_cfg_t;

  // Software controls held in the clock control register
  typedef struct packed {
    logic stop_en;
    logic [2:0] wake_level;
  } pcc_ctrl_t;

endpackage

// ---- design/pcc_clkdiv.sv ----
// Bus clock divider: core clock divided by two, three or four
`timescale 1ns/1ps
`default_nettype none
`include "pcc_params.svh"

module pcc_clkdiv (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_run,
  input wire logic [1:0] i_ratio,
  // Divided clock
  output logic o_bclk,
  output logic o_rise
);

  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;
  logic bclk_ff;
  logic nxt_bclk;
  logic rise_ff;
  logic nxt_rise;
  logic [1:0] last;
  logic [1:0] half;

  // Decode the divisor; the unused code falls back to a quarter, the slowest safe rate
  always_comb begin
    case (i_ratio)
      `PCC_RATIO_HALF: begin
        last = 2'h1;
        half = 2'h1;
      end
      `PCC_RATIO_THIRD: begin
        last = 2'h2;
        half = 2'h1;
      end
      default: begin
        last = 2'h3;
        half = 2'h2;
      end
    endcase
  end

  // Phase counter; output high in the first part of each period, low while stopped.
  // While stopped it parks on the last phase so the first period after start is whole.
  always_comb begin
    nxt_cnt = last;
    nxt_bclk = 1'b0;
    nxt_rise = 1'b0;
    if (i_run) begin
      nxt_cnt = (cnt_ff >= last) ? 2'h0 : cnt_ff + 2'h1;
      nxt_bclk = (nxt_cnt < half);
      nxt_rise = nxt_bclk & ~bclk_ff;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= 2'h0;
      bclk_ff <= 1'b0;
      rise_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      bclk_ff <= nxt_bclk;
      rise_ff <= nxt_rise;
    end
  end

  assign o_bclk = bclk_ff;
  assign o_rise = rise_ff;

endmodule

`default_nettype wire

// ---- design/pcc_top.sv ----
// Clock generation, reset configuration and reset stretching block
`timescale 1ns/1ps
`default_nettype none
`include "pcc_params.svh"

module pcc_top #(
  // Lock time in reference cycles and core cycles per reference cycle
  parameter int LOCK_REF_CYCLES = `PCC_LOCK_REF_CYCLES,
  parameter int CORE_PER_REF = `PCC_CORE_PER_REF,
  // Bus clock cycles that reset-out outlasts lock
  parameter int RESET_OUT_N_BUS_CYCLES = `PCC_RESET_OUT_N_BUS_CYCLES
) (
  // Core clock (twice the reference) and asynchronous reset
  input wire logic I_CORE_CLK,
  input wire logic I_RESETN,
  // Data lines carrying the configuration straps during reset
  input wire logic [7:0] I_DATA,
  // Processor stop request and pending interrupt level
  input wire logic I_STOP_REQ,
  input wire logic [2:0] I_IRQ_LEVEL,
  // Register port
  input wire logic [`PCC_ADDR_W-1:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  // Generated clocks and resets
  output logic O_BUS_CLOCK_OUT,
  output logic O_TRACE_STATUS_CLOCK,
  output logic O_RESET_OUT_N,
  output logic O_CORE_CLK_EN
);

  // ------------------------------------------------------------
  // Derived counts
  // ------------------------------------------------------------
  // Lock interval counted in core cycles: reference cycles times core-per-reference
  localparam int LOCK_CORE_CYCLES = LOCK_REF_CYCLES * CORE_PER_REF;
  localparam int LOCK_W = $clog2(LOCK_CORE_CYCLES + 1);
  localparam int EXT_W = $clog2(RESET_OUT_N_BUS_CYCLES + 1);
  localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(LOCK_CORE_CYCLES - 1);
  localparam logic [EXT_W-1:0] EXT_LAST = EXT_W'(RESET_OUT_N_BUS_CYCLES);
  // Control reset value split into fields; stop stays disabled out of reset
  localparam logic [7:0] CTRL_RST_WORD = `PCC_CTRL_RESET;
  localparam pcc_pkg::pcc_ctrl_t CTRL_RST = '{
    stop_en: CTRL_RST_WORD[`PCC_CTRL_STOP_BIT],
    wake_level: CTRL_RST_WORD[`PCC_CTRL_WAKE_MSB:`PCC_CTRL_WAKE_LSB]
  };

  // ------------------------------------------------------------
  // Strap capture
  // ------------------------------------------------------------
  pcc_pkg::pcc_cfg_t cfg_ff;
  pcc_pkg::pcc_cfg_t nxt_cfg;

  // Straps follow the data lines only while reset is held, so the value kept
  // is the one present at the last edge before release; a reference change
  // seen while running is never picked up. This register has no async reset
  // on purpose: it must keep working while the reset pin is low.
  always_comb begin
    nxt_cfg = cfg_ff;
    if (!I_RESETN) begin
      nxt_cfg.strap = I_DATA;
      nxt_cfg.range = I_DATA[`PCC_STRAP_RANGE_MSB:`PCC_STRAP_RANGE_LSB];
      nxt_cfg.ratio = I_DATA[`PCC_STRAP_RATIO_MSB:`PCC_STRAP_RATIO_LSB];
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    cfg_ff <= nxt_cfg;
  end

  // ------------------------------------------------------------
  // Lock and reset-out sequencer
  // ------------------------------------------------------------
  pcc_pkg::pcc_state_t state_ff;
  pcc_pkg::pcc_state_t nxt_state;
  logic [LOCK_W-1:0] lock_cnt_ff;
  logic [LOCK_W-1:0] nxt_lock_cnt;
  logic [EXT_W-1:0] ext_cnt_ff;
  logic [EXT_W-1:0] nxt_ext_cnt;
  logic reset_out_n_n_ff;
  logic nxt_reset_out_n_n;
  logic clk_run_ff;
  logic nxt_clk_run;
  logic bus_rise;
  logic bus_clk;

  // The async reset returns everything here to the start of the lock count,
  // so a reset asserted mid-lock restarts the whole interval. No reference
  // clock reaches this block, so the interval is counted in core cycles.
  always_comb begin
    nxt_state = state_ff;
    nxt_lock_cnt = lock_cnt_ff;
    nxt_ext_cnt = ext_cnt_ff;
    nxt_reset_out_n_n = reset_out_n_n_ff;
    nxt_clk_run = clk_run_ff;
    case (state_ff)
      pcc_pkg::PCC_ST_LOCK: begin
        // No analog lock detect: a fixed count covers the worst case
        if (lock_cnt_ff == LOCK_LAST) begin
          nxt_state = pcc_pkg::PCC_ST_EXTEND;
          nxt_clk_run = 1'b1;
        end else begin
          nxt_lock_cnt = lock_cnt_ff + 1'b1;
        end
      end
      pcc_pkg::PCC_ST_EXTEND: begin
        // Count bus clock rising edges before releasing peripherals, so that
        // clocked peripherals see several edges while still held in reset
        if (ext_cnt_ff == EXT_LAST) begin
          nxt_state = pcc_pkg::PCC_ST_RUN;
          nxt_reset_out_n_n = 1'b1;
        end else if (bus_rise) begin
          nxt_ext_cnt = ext_cnt_ff + 1'b1;
        end
      end
      pcc_pkg::PCC_ST_RUN: begin
        // Peripherals released; stays here until the next reset
        nxt_reset_out_n_n = 1'b1;
      end
      default: begin
        // Unused code: return to the lock state, keeping the lock count, rather than run unlocked
        nxt_state = pcc_pkg::PCC_ST_LOCK;
      end
    endcase
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state_ff <= pcc_pkg::PCC_ST_LOCK;
      lock_cnt_ff <= '0;
      ext_cnt_ff <= '0;
      reset_out_n_n_ff <= 1'b0;
      clk_run_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      lock_cnt_ff <= nxt_lock_cnt;
      ext_cnt_ff <= nxt_ext_cnt;
      reset_out_n_n_ff <= nxt_reset_out_n_n;
      clk_run_ff <= nxt_clk_run;
    end
  end

  // ------------------------------------------------------------
  // Sequencer decode
  // ------------------------------------------------------------
  logic seq_run;
  logic bad_range;

  // Stop requests count only once the peripherals have left reset; a stop
  // taken during lock would freeze the core before its reset had finished
  assign seq_run = (state_ff == pcc_pkg::PCC_ST_RUN);

  // An unused range code cannot be refused here; it is only reported
  assign bad_range = (cfg_ff.range == `PCC_RANGE_UNUSED);

  // ------------------------------------------------------------
  // Bus clock divider
  // ------------------------------------------------------------
  // The divider is held stopped, so its output stays low, until lock
  pcc_clkdiv u_div (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RESETN),
    .i_run(clk_run_ff),
    .i_ratio(cfg_ff.ratio),
    .o_bclk(bus_clk),
    .o_rise(bus_rise)
  );

  // ------------------------------------------------------------
  // Control register and stop logic
  // ------------------------------------------------------------
  pcc_pkg::pcc_ctrl_t ctrl_ff;
  pcc_pkg::pcc_ctrl_t nxt_ctrl;
  logic stopped_ff;
  logic nxt_stopped;
  logic wake_hit;
  logic wr_ctrl;

  // Only the control register takes writes; anything else is dropped
  assign wr_ctrl = I_WR && (I_ADDR == `PCC_ADDR_CTRL);

  // Minimum level compare; the all-ones code lets no interrupt through
  assign wake_hit = (I_IRQ_LEVEL != `PCC_IRQ_NONE) &&
                    (ctrl_ff.wake_level != `PCC_WAKE_NONE) &&
                    (I_IRQ_LEVEL >= ctrl_ff.wake_level);

  // Only the core clock is gated; this block and the bus clock keep running
  // so that interrupts can still arrive. While stopped, a wake beats a stop request in the same cycle; a wake clears only a stop already in force.
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_stopped = stopped_ff;
    if (wr_ctrl) begin
      nxt_ctrl.stop_en = I_WDATA[`PCC_CTRL_STOP_BIT];
      nxt_ctrl.wake_level = I_WDATA[`PCC_CTRL_WAKE_MSB:`PCC_CTRL_WAKE_LSB];
    end
    if (stopped_ff && wake_hit) begin
      nxt_stopped = 1'b0;
    end else if (I_STOP_REQ && ctrl_ff.stop_en && seq_run) begin
      nxt_stopped = 1'b1;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ctrl_ff <= CTRL_RST;
      stopped_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      stopped_ff <= nxt_stopped;
    end
  end

  // ------------------------------------------------------------
  // Register read port
  // ------------------------------------------------------------
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [31:0] stat_word;
  logic [31:0] ctrl_word;

  // Reserved control bits read as zero, so software may write back
  // whatever it read without side effects
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[`PCC_CTRL_STOP_BIT] = ctrl_ff.stop_en;
    ctrl_word[`PCC_CTRL_WAKE_MSB:`PCC_CTRL_WAKE_LSB] = ctrl_ff.wake_level;
  end

  // Status word shows lock progress and the configuration caught at reset.
  // Low nibble: locked, reset-out released, core stopped, bad range code;
  // then range, ratio and the whole strap byte. The straps are valid as
  // soon as reset is released, well before lock.
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[`PCC_STAT_LOCKED_BIT] = clk_run_ff;
    stat_word[`PCC_STAT_RESET_OUT_N_BIT] = reset_out_n_n_ff;
    stat_word[`PCC_STAT_STOPPED_BIT] = stopped_ff;
    stat_word[`PCC_STAT_BAD_RANGE_BIT] = bad_range;
    stat_word[`PCC_STAT_RANGE_LSB +: 2] = cfg_ff.range;
    stat_word[`PCC_STAT_RATIO_LSB +: 2] = cfg_ff.ratio;
    stat_word[`PCC_STAT_STRAP_LSB +: 8] = cfg_ff.strap;
  end

  // Unmapped addresses read zero; data appear only in the cycle after the strobe.
  // Outside that cycle the port reads zero, which keeps a shared bus quiet.
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (I_RD) begin
      case (I_ADDR)
        `PCC_ADDR_CTRL: nxt_rdata = ctrl_word;
        `PCC_ADDR_STAT: nxt_rdata = stat_word;
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Read data come straight from their flop, clean for a full cycle
  assign O_RDATA = rdata_ff;
  // Divided clock leaves from a flop, free of decode glitches
  assign O_BUS_CLOCK_OUT = bus_clk;
  // Gated copy of the core clock: same rate, a gate delay late, low until lock.
  // The enable changes right after a rising edge, while the clock is high, so the first pulse comes out short.
  assign O_TRACE_STATUS_CLOCK = I_CORE_CLK & clk_run_ff;
  // Peripheral reset from a flop; low from reset input until the stretch ends
  assign O_RESET_OUT_N = reset_out_n_n_ff;
  // Core clock enable: low until lock and while a stop is in force
  assign O_CORE_CLK_EN = clk_run_ff & ~stopped_ff;

endmodule

`default_nettype wire

// ---- tb/pcc_props.sv ----
// Checker on the top ports of the clock and reset-configuration block
`timescale 1ns/1ps
`default_nettype none
module pcc_props #(
  parameter int LOCK_REF_CYCLES = 10,
  parameter int CORE_PER_REF = 2,
  parameter int RESET_OUT_N_BUS_CYCLES = 2
) (
  // Clock, reset, straps and read strobe
  input wire logic I_CORE_CLK,
  input wire logic I_RESETN,
  input wire logic [7:0] I_DATA,
  input wire logic I_RD,
  // Watched outputs
  input wire logic [31:0] O_RDATA,
  input wire logic O_BUS_CLOCK_OUT,
  input wire logic O_RESET_OUT_N,
  input wire logic O_CORE_CLK_EN
);
  localparam int LCK = LOCK_REF_CYCLES * CORE_PER_REF;
  int cyc_ff;
  int rise_ff;
  int nxt_cyc;
  int nxt_rise;
  logic bus_q_ff;
  logic [1:0] ratio_ff;
  // Cycles since release, saturating just past LCK, and bus clock rises, not saturating
  always_comb begin
    nxt_cyc = (cyc_ff <= LCK) ? cyc_ff + 1 : cyc_ff;
    nxt_rise = (O_BUS_CLOCK_OUT && !bus_q_ff) ? rise_ff + 1 : rise_ff;
  end
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      cyc_ff <= 0;
      rise_ff <= 0;
      bus_q_ff <= 1'b0;
    end else begin
      cyc_ff <= nxt_cyc;
      rise_ff <= nxt_rise;
      bus_q_ff <= O_BUS_CLOCK_OUT;
    end
  end
  // Ratio strap seen while reset is held
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESETN) begin
      ratio_ff <= I_DATA[1:0];
    end
  end
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESETN);
  a_quiet_release: assert property ($rose(I_RESETN) |->
    !O_BUS_CLOCK_OUT && !O_RESET_OUT_N && !O_CORE_CLK_EN)
    else $error("outputs active at reset release");
  a_clocks_held: assert property (cyc_ff < LCK |-> !O_BUS_CLOCK_OUT && !O_RESET_OUT_N)
    else $error("bus clock or reset out during lock");
  a_clock_start: assert property (cyc_ff == LCK |-> ##[1:6] O_BUS_CLOCK_OUT)
    else $error("bus clock did not start after lock");
  a_reset_out_n_hold: assert property (rise_ff < RESET_OUT_N_BUS_CYCLES |-> !O_RESET_OUT_N)
    else $error("reset out released too early");
  a_reset_out_n_release: assert property (cyc_ff == LCK |-> ##[1:1000] O_RESET_OUT_N)
    else $error("reset out never released");
  a_reset_out_n_sticky: assert property (O_RESET_OUT_N |=> O_RESET_OUT_N)
    else $error("reset out dropped while running");
  a_bus_half: assert property ($rose(O_BUS_CLOCK_OUT) && ratio_ff == 2'h2 |=>
    !O_BUS_CLOCK_OUT ##1 O_BUS_CLOCK_OUT) else $error("half ratio shape wrong");
  a_bus_third: assert property ($rose(O_BUS_CLOCK_OUT) && ratio_ff == 2'h3 |=>
    !O_BUS_CLOCK_OUT [*2] ##1 O_BUS_CLOCK_OUT) else $error("third ratio shape wrong");
  a_bus_quarter: assert property ($rose(O_BUS_CLOCK_OUT) && !ratio_ff[1] |=>
    O_BUS_CLOCK_OUT ##1 !O_BUS_CLOCK_OUT [*2] ##1 O_BUS_CLOCK_OUT)
    else $error("quarter shape wrong");
  a_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 32'h0)
    else $error("read data outside read slot");
  c_reset_out_n: cover property ($rose(O_RESET_OUT_N));
  c_stop: cover property ($fell(O_CORE_CLK_EN));
  c_third: cover property ($rose(O_BUS_CLOCK_OUT) && ratio_ff == 2'h3);
endmodule
bind pcc_top pcc_props #(.LOCK_REF_CYCLES(LOCK_REF_CYCLES), .CORE_PER_REF(CORE_PER_REF),
  .RESET_OUT_N_BUS_CYCLES(RESET_OUT_N_BUS_CYCLES)) i_props (.I_CORE_CLK(I_CORE_CLK), .I_RESETN(I_RESETN),
  .I_DATA(I_DATA), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_BUS_CLOCK_OUT(O_BUS_CLOCK_OUT),
  .O_RESET_OUT_N(O_RESET_OUT_N), .O_CORE_CLK_EN(O_CORE_CLK_EN));
`default_nettype wire

// ---- tb/pcc_board.sv ----
// Board model: reset source and strapping on the data lines
`timescale 1ns/1ps
`default_nettype none
module pcc_board #(
  parameter int HOLD = 160
) (
  // Clock
  input wire logic i_clk,
  // Reset request and strap levels
  input wire logic i_req,
  input wire logic [3:0] i_strap,
  // Board reset and data lines
  output logic o_resetn,
  output logic [7:0] o_data
);
  int cnt_ff = 0;
  int nxt_cnt;
  logic [7:0] pat_ff = 8'hA5;
  // Reset is held for the full count, never cut short
  always_comb begin
    nxt_cnt = cnt_ff;
    if (i_req) begin
      nxt_cnt = HOLD;
    end else if (cnt_ff != 0) begin
      nxt_cnt = cnt_ff - 1;
    end
  end
  always_ff @(posedge i_clk) begin
    cnt_ff <= nxt_cnt;
    pat_ff <= ~pat_ff;
  end
  assign o_resetn = (cnt_ff == 0);
  // Straps only while reset is held; afterwards the lines keep changing
  assign o_data = o_resetn ? pat_ff : {4'h5, i_strap};
endmodule
`default_nettype wire

// ---- tb/pcc_top_tb_top.sv ----
// Testbench for the clock and reset-configuration block
`timescale 1ns/1ps
`default_nettype none
module pcc_top_tb_top;
  localparam int LCK = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  logic [3:0] strap = 4'h0;
  logic stop = 1'b0;
  logic [2:0] irq = 3'h0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic resetn_b;
  logic [7:0] data;
  logic [31:0] rdata;
  logic bus, trc, reset_out_n, cen;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  pcc_board #(.HOLD(160)) i_board (.i_clk(clk), .i_req(req), .i_strap(strap),
    .o_resetn(resetn_b), .o_data(data));
  pcc_top #(.LOCK_REF_CYCLES(10), .CORE_PER_REF(2), .RESET_OUT_N_BUS_CYCLES(2)) i_dut (
    .I_CORE_CLK(clk), .I_RESETN(rst_n & resetn_b), .I_DATA(data), .I_STOP_REQ(stop),
    .I_IRQ_LEVEL(irq), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .O_BUS_CLOCK_OUT(bus), .O_TRACE_STATUS_CLOCK(trc),
    .O_RESET_OUT_N(reset_out_n), .O_CORE_CLK_EN(cen));
  // Verdict and end of run
  task print_verdict;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tick;
    @(posedge clk);
    #1;
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data is looked at only in the cycle after the strobe
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task pulse(input logic is_req);
    @(posedge clk);
    if (is_req) req <= 1'b1; else stop <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    stop <= 1'b0;
  endtask
  task wait_release;
    int n;
    n = 0;
    tick;
    while (!resetn_b && n < 400) begin
      tick;
      n++;
    end
  endtask
  // Full reset with straps: lock quiet time, clock shape, reset-out, status
  task boot(input logic [3:0] s);
    int n;
    int hi;
    int per;
    strap <= s;
    pulse(1'b1);
    wait_release;
    for (n = 0; n < LCK - 2; n++) begin
      tick;
      chk({bus, trc}, 2'b00);
    end
    n = 0;
    while (!bus && n < 50) begin
      tick;
      n++;
    end
    chk({bus, trc}, 2'b11);
    hi = 0;
    while (bus && hi < 9) begin
      tick;
      hi++;
    end
    per = hi;
    while (!bus && per < 9) begin
      tick;
      per++;
    end
    chk({hi[3:0], per[3:0]}, (s[1:0] == 2'h2) ? 8'h12 : (s[1:0] == 2'h3) ? 8'h13 : 8'h24);
    n = 0;
    while (!reset_out_n && n < 60) begin
      tick;
      n++;
    end
    chk({reset_out_n, cen}, 2'b11);
    rd_chk(8'h04, {16'h0, 4'h5, s, s[1:0], s[3:2], 4'h3});
  endtask
  task t_regs;
    rd_chk(8'h00, 32'h0);
    wr_reg(8'h00, 32'hFFFF_FFFF);
    rd_chk(8'h00, 32'hF0);
    wr_reg(8'h08, 32'h0);
    rd_chk(8'h08, 32'h0);
    rd_chk(8'h00, 32'hF0);
  endtask
  // Stop only when enabled; wake only at or above the wake level
  task t_stop;
    wr_reg(8'h00, 32'h0);
    pulse(1'b0);
    repeat (3) tick;
    chk(cen, 1'b1);
    wr_reg(8'h00, 32'hB0);
    pulse(1'b0);
    repeat (2) tick;
    chk(cen, 1'b0);
    @(posedge clk);
    irq <= 3'h2;
    repeat (3) tick;
    chk(cen, 1'b0);
    @(posedge clk);
    irq <= 3'h3;
    repeat (2) tick;
    chk(cen, 1'b1);
    wr_reg(8'h00, 32'hF0);
    irq <= 3'h7;
    pulse(1'b0);
    repeat (3) tick;
    chk(cen, 1'b0);
    @(posedge clk);
    irq <= 3'h0;
  endtask
  // Reset again in mid-lock: count restarts from zero
  task t_restart;
    strap <= 4'h6;
    pulse(1'b1);
    wait_release;
    repeat (LCK / 2) tick;
    rd_chk(8'h04, 32'h0000_5690);
    boot(4'h2);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    boot(4'h2);
    t_regs;
    t_stop;
    boot(4'h3);
    boot(4'h4);
    boot(4'h9);
    t_restart;
    print_verdict;
  end
endmodule
`default_nettype wire
